/* File: design/sasr_pkg.sv */
/*
 sasr_pkg: offsets, field layouts, reset values and carrier structs for the
 spectral alarm status register group.
 assumes: 16-bit registers on even byte addresses of the host register port.
*/
package sasr_pkg;
	localparam int unsigned NUM_AXES  = 3;
	localparam int unsigned NUM_BANDS = 6;
	localparam int unsigned ADDR_W    = 7;
	localparam int unsigned WORD_W    = 16;

	localparam logic [6:0] OFS_ALARM_STATUS_X = 7'h40;
	localparam logic [6:0] OFS_ALARM_STATUS_Y = 7'h42;
	localparam logic [6:0] OFS_ALARM_STATUS_Z = 7'h44;
	localparam logic [6:0] OFS_ALARM_PEAK_X   = 7'h46;
	localparam logic [6:0] OFS_ALARM_PEAK_Y   = 7'h48;
	localparam logic [6:0] OFS_ALARM_PEAK_Z   = 7'h4a;
	localparam logic [6:0] OFS_SECONDS_LOW    = 7'h4c;
	localparam logic [6:0] OFS_SECONDS_HIGH   = 7'h4e;
	localparam logic [6:0] OFS_DAY_REVISION   = 7'h52;

	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [15:0] UNMAPPED_WORD = 16'h0000;

	// band field positions inside an alarm status word
	localparam int unsigned FLAG_BASE_BIT = 4;
	localparam int unsigned FLAG_TOP_BIT  = 15;
	localparam logic [2:0] BAND_MIN = 3'h1;
	localparam logic [2:0] BAND_MAX = 3'h6;
	localparam logic [2:0] BAND_NONE = 3'h0;

	// diagnostic summary bits
	localparam int unsigned DIAG_LVL1_BIT = 8;
	localparam int unsigned DIAG_LVL2_BIT = 11;

	// seconds tick: 25 MHz clock
	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned TICK_SEC   = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_SEC;

	typedef struct packed {
		logic [5:0] lvl2;
		logic [5:0] lvl1;
		logic [2:0] band;
	} sasr_axis_t;

	typedef struct packed {
		logic        valid;
		sasr_axis_t  x;
		sasr_axis_t  y;
		sasr_axis_t  z;
		logic [15:0] peak_x;
		logic [15:0] peak_y;
		logic [15:0] peak_z;
	} sasr_result_t;

	typedef struct packed {
		logic [3:0] day_tens;
		logic [3:0] day_units;
		logic [3:0] rev_msd;
		logic [3:0] rev_lsd;
	} sasr_day_rev_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
	} sasr_req_t;

	// pack band flags: band n level 1 at bit 2n+2, level 2 at bit 2n+3
	function automatic logic [15:0] sasr_pack_status(input sasr_axis_t a);
		logic [15:0] w;
		w = RST_WORD;
		for (int n = 1; n <= NUM_BANDS; n++) begin
			w[2*n+2] = a.lvl1[n-1];
			w[2*n+3] = a.lvl2[n-1];
		end
		w[2:0] = ((a.band >= BAND_MIN) && (a.band <= BAND_MAX)) ? a.band : BAND_NONE;
		return w;
	endfunction
endpackage

/* File: design/sasr_seconds.sv */
/*
 sasr_seconds: free-running seconds counter, 32 bits, derived from clk_sys.
 assumes: 25 MHz clock; CYCLES parameter (default SEC_CYCLES) can be shortened in simulation.
*/
`timescale 1ns/100ps
`default_nettype none
module sasr_seconds
	import sasr_pkg::*;
#(
	parameter int unsigned CYCLES = SEC_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// count
	output logic [31:0]      seconds
);
	typedef struct packed {
		logic [24:0] div;
		logic [31:0] sec;
	} sasr_sec_st_t;

	sasr_sec_st_t st;
	sasr_sec_st_t next_st;

	always_comb begin
		next_st = st;
		if (st.div == 25'(CYCLES - 1)) begin
			next_st.div = '0;
			next_st.sec = st.sec + 32'h0000_0001;
		end else begin
			next_st.div = st.div + 25'h000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign seconds = st.sec;

	second_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st.div == 25'(CYCLES - 1)) |=> (st.sec == $past(st.sec) + 32'h0000_0001))
		else $error("seconds did not advance at divider wrap");
endmodule
`default_nettype wire

/* File: design/sasr_read_mux.sv */
/*
 sasr_read_mux: address decode of the read-only register words.
 assumes: word-aligned even address; odd address selects the same word.
*/
`timescale 1ns/100ps
`default_nettype none
module sasr_read_mux
	import sasr_pkg::*;
(
	// address
	input  wire logic [6:0]  addr,
	// register words
	input  wire logic [15:0] stat_x,
	input  wire logic [15:0] stat_y,
	input  wire logic [15:0] stat_z,
	input  wire logic [15:0] peak_x,
	input  wire logic [15:0] peak_y,
	input  wire logic [15:0] peak_z,
	input  wire logic [31:0] seconds,
	input  wire logic [15:0] day_rev,
	// result
	output logic [15:0]      rdata,
	output logic             hit
);
	logic [6:0] word_addr;

	always_comb begin
		word_addr = {addr[6:1], 1'b0};
		hit       = 1'b1;
		unique case (word_addr)
			OFS_ALARM_STATUS_X: rdata = stat_x;
			OFS_ALARM_STATUS_Y: rdata = stat_y;
			OFS_ALARM_STATUS_Z: rdata = stat_z;
			OFS_ALARM_PEAK_X:   rdata = peak_x;
			OFS_ALARM_PEAK_Y:   rdata = peak_y;
			OFS_ALARM_PEAK_Z:   rdata = peak_z;
			OFS_SECONDS_LOW:    rdata = seconds[15:0];
			OFS_SECONDS_HIGH:   rdata = seconds[31:16];
			OFS_DAY_REVISION:   rdata = day_rev;
			default: begin
				rdata = UNMAPPED_WORD;
				hit   = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: design/sasr_regs.sv */
/*
 sasr_regs: spectral alarm status register group, read-only to the host.
 holds per-axis alarm status, peak magnitudes, capture seconds stamp,
 factory day / firmware revision word and the diagnostic summary bits.
 assumes: the alarm engine presents one-cycle result pulses; host register
 port is synchronous to clk_sys; day and revision come from factory straps.
*/
// Notes on behaviour
// - status word bits 4..15: band n level 1 at 2n+2, level 2 at 2n+3
// - x status bits 2..0 give band of largest delta, 1..6; bit 3 unused
// - y and z status bits 2..0 give most critical band, 1..6
// - one read-only status word per axis, all zero after reset
// - per-axis peak word holds 16-bit magnitude of the peak alarm bin
// - seconds stamp of most recent capture kept over two read words
// - low half at lower address, high half next; both reset to zero
// - day of month as two decimal digits in bits 15:12 and 11:8
// - firmware revision as two decimal digits in bits 7:4 and 3:0
// - summary alarm per axis: level 1 bits 8..10, level 2 bits 11..13; code drives them only on diag_alarm_lvl1 and diag_alarm_lvl2, in no read word
`timescale 1ns/100ps
`default_nettype none
module sasr_regs
	import sasr_pkg::*;
#(
	parameter int unsigned SEC_TICK_CYCLES = SEC_CYCLES
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	// host register port
	input  wire sasr_req_t     req,
	input  wire logic [15:0]   wdata,
	output logic [15:0]        rdata,
	output logic               rvalid,
	output logic               addr_hit,
	// alarm engine
	input  wire sasr_result_t  result,
	input  wire logic          capture_event,
	// factory straps
	input  wire sasr_day_rev_t day_rev_in,
	// diagnostic summary
	output logic [2:0]         diag_alarm_lvl1,
	output logic [2:0]         diag_alarm_lvl2
);
	typedef struct packed {
		logic [15:0]   stat_x;
		logic [15:0]   stat_y;
		logic [15:0]   stat_z;
		logic [15:0]   peak_x;
		logic [15:0]   peak_y;
		logic [15:0]   peak_z;
		logic [31:0]   stamp;
		sasr_day_rev_t day_rev;
		logic          straps_taken;
		logic [15:0]   rdata;
		logic          rvalid;
		logic          hit;
	} sasr_state_t;

	sasr_state_t st;
	sasr_state_t next_st;
	logic [31:0] seconds;
	logic [15:0] mux_data;
	logic        mux_hit;
	logic [15:0] day_word;

	sasr_seconds #(
		.CYCLES (SEC_TICK_CYCLES)
	) u_seconds (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.seconds (seconds)
	);

	assign day_word = st.day_rev;

	sasr_read_mux u_mux (
		.addr    (req.addr),
		.stat_x  (st.stat_x),
		.stat_y  (st.stat_y),
		.stat_z  (st.stat_z),
		.peak_x  (st.peak_x),
		.peak_y  (st.peak_y),
		.peak_z  (st.peak_z),
		.seconds (st.stamp),
		.day_rev (day_word),
		.rdata   (mux_data),
		.hit     (mux_hit)
	);

	// write data is never stored: every word here is read-only

	always_comb begin
		next_st = st;
		// straps caught once after reset release, not under reset
		if (!st.straps_taken) begin
			next_st.day_rev      = day_rev_in;
			next_st.straps_taken = 1'b1;
		end
		if (result.valid) begin
			next_st.stat_x = sasr_pack_status(result.x);
			next_st.stat_y = sasr_pack_status(result.y);
			next_st.stat_z = sasr_pack_status(result.z);
			next_st.peak_x = result.peak_x;
			next_st.peak_y = result.peak_y;
			next_st.peak_z = result.peak_z;
		end
		if (capture_event) begin
			next_st.stamp = seconds;
		end
		next_st.rvalid = req.rd;
		next_st.hit    = req.rd & mux_hit;
		next_st.rdata  = req.rd ? mux_data : st.rdata;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata    = st.rdata;
	assign rvalid   = st.rvalid;
	assign addr_hit = st.hit;

	// or of one alarm level over the six bands; first is that level's band 1 bit
	function automatic logic any_band(input logic [15:0] w, input int unsigned first);
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < NUM_BANDS; n++) begin
			seen = seen | w[first + 2 * n];
		end
		return seen;
	endfunction

	// summary flag set when any band of that axis and level is active
	always_comb begin
		diag_alarm_lvl1 = {any_band(st.stat_z, FLAG_BASE_BIT),
			any_band(st.stat_y, FLAG_BASE_BIT),
			any_band(st.stat_x, FLAG_BASE_BIT)};
		diag_alarm_lvl2 = {any_band(st.stat_z, FLAG_BASE_BIT + 1),
			any_band(st.stat_y, FLAG_BASE_BIT + 1),
			any_band(st.stat_x, FLAG_BASE_BIT + 1)};
	end

	// assertions
	sequence s_result;
		result.valid;
	endsequence

	// a read of the word that holds byte address a
	sequence s_read(logic [6:0] a);
		req.rd && (req.addr[6:1] == a[6:1]);
	endsequence

	status_x_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_result |=> (st.stat_x == sasr_pack_status($past(result.x))))
		else $error("x status word not loaded from result");

	band_x_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st.stat_x[3] == 1'b0) && (st.stat_x[2:0] <= BAND_MAX))
		else $error("x band field out of range");

	band_yz_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st.stat_y[3] == 1'b0) && (st.stat_z[3] == 1'b0) && (st.stat_y[2:0] <= BAND_MAX) &&
		(st.stat_z[2:0] <= BAND_MAX))
		else $error("y or z band field illegal");

	status_reset_a: assert property (@(posedge clk_sys)
		$past(sys_rst) |-> (st.stat_x == RST_WORD) && (st.stat_y == RST_WORD) &&
		(st.stat_z == RST_WORD))
		else $error("status word not zero after reset");

	peak_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!result.valid |=> $stable(st.peak_x) && $stable(st.peak_y) && $stable(st.peak_z))
		else $error("peak changed without result");

	stamp_capture_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		capture_event |=> (st.stamp == $past(seconds)))
		else $error("stamp not captured from seconds");

	stamp_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && req.addr == OFS_SECONDS_HIGH) |=> rvalid && (rdata == $past(st.stamp[31:16])))
		else $error("high stamp half read wrong");

	day_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && req.addr == OFS_DAY_REVISION) |=> (rdata[15:8] == $past(day_word[15:8])))
		else $error("day digits read wrong");

	rev_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && req.addr == OFS_DAY_REVISION) |=> (rdata[7:0] == $past(day_word[7:0])))
		else $error("revision digits read wrong");

	diag_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_result |=> (diag_alarm_lvl1 == {|$past(result.z.lvl1), |$past(result.y.lvl1),
		|$past(result.x.lvl1)}))
		else $error("level 1 summary mismatch");

	write_ignored_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.wr && !result.valid) |=> $stable(st.stat_x) && $stable(st.peak_z))
		else $error("write altered read-only word");

	status_yz_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_result |=> (st.stat_y == sasr_pack_status($past(result.y))) &&
		(st.stat_z == sasr_pack_status($past(result.z))))
		else $error("y or z status word not loaded from result");

	// bit placement checked apart from the packing function
	flag_place_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_result |=> (st.stat_x[FLAG_BASE_BIT] == $past(result.x.lvl1[0])) &&
		(st.stat_x[FLAG_TOP_BIT] == $past(result.x.lvl2[NUM_BANDS - 1])))
		else $error("band flag in wrong bit");

	band_clip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(result.valid && ((result.x.band < BAND_MIN) || (result.x.band > BAND_MAX)))
		|=> (st.stat_x[2:0] == BAND_NONE))
		else $error("illegal x band not reported as none");

	band_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(result.valid && (result.y.band >= BAND_MIN) && (result.y.band <= BAND_MAX))
		|=> (st.stat_y[2:0] == $past(result.y.band)))
		else $error("legal y band not reported");

	status_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!result.valid |=> $stable(st.stat_x) && $stable(st.stat_y) && $stable(st.stat_z))
		else $error("status changed without result");

	status_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_read(OFS_ALARM_STATUS_Y) |=> rvalid && addr_hit && (rdata == $past(st.stat_y)))
		else $error("y status read wrong");

	rdata_reset_a: assert property (@(posedge clk_sys)
		$past(sys_rst) |-> (rdata == RST_WORD) && !rvalid && !addr_hit)
		else $error("read port not idle after reset");

	peak_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_result |=> (st.peak_x == $past(result.peak_x)) &&
		(st.peak_y == $past(result.peak_y)) && (st.peak_z == $past(result.peak_z)))
		else $error("peak word not loaded from result");

	peak_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_read(OFS_ALARM_PEAK_Z) |=> rvalid && (rdata == $past(st.peak_z)))
		else $error("z peak read wrong");

	peak_x_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_read(OFS_ALARM_PEAK_X) |=> rvalid && (rdata == $past(st.peak_x)))
		else $error("x peak read wrong");

	peak_reset_a: assert property (@(posedge clk_sys)
		$past(sys_rst) |-> (st.peak_x == RST_WORD) && (st.peak_y == RST_WORD) &&
		(st.peak_z == RST_WORD))
		else $error("peak word not zero after reset");

	// the stamp only moves on a capture, so a read pair stays coherent meanwhile
	stamp_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!capture_event |=> $stable(st.stamp))
		else $error("stamp changed without capture");

	stamp_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_read(OFS_SECONDS_LOW) |=> rvalid && (rdata == $past(st.stamp[15:0])))
		else $error("low stamp half read wrong");

	stamp_reset_a: assert property (@(posedge clk_sys)
		$past(sys_rst) |-> (st.stamp == '0))
		else $error("stamp not zero after reset");

	straps_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(st.straps_taken) |-> (st.day_rev == $past(day_rev_in)))
		else $error("day and revision straps not taken");

	straps_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st.straps_taken |=> $stable(st.day_rev))
		else $error("day and revision word moved after capture");

	diag_level2_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_result |=> (diag_alarm_lvl2 == {|$past(result.z.lvl2), |$past(result.y.lvl2),
		|$past(result.x.lvl2)}))
		else $error("level 2 summary mismatch");

	diag_reset_a: assert property (@(posedge clk_sys)
		$past(sys_rst) |-> (diag_alarm_lvl1 == 3'h0) && (diag_alarm_lvl2 == 3'h0))
		else $error("summary flags not clear after reset");

	odd_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && req.addr[0] && (req.addr[6:1] == OFS_DAY_REVISION[6:1]))
		|=> (rdata == $past(day_word)))
		else $error("odd byte address read another word");

	unmapped_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && !mux_hit) |=> rvalid && !addr_hit && (rdata == UNMAPPED_WORD))
		else $error("unmapped read not answered with zero");

	write_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.wr && !req.rd) |=> !rvalid && !addr_hit)
		else $error("write produced a read answer");

	write_data_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.wr && !req.rd && (wdata != st.rdata)) |=> $stable(rdata))
		else $error("write data reached the read port");

	hit_valid_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		addr_hit |-> rvalid)
		else $error("address hit without read answer");
endmodule
`default_nettype wire

/* File: verif/sasr_host_model.sv */
/*
 sasr_host_model: host side of the register port, one access at a time.
 assumes: rvalid answers one cycle after the edge that takes the request.
*/
`timescale 1ns/100ps
`default_nettype none
module sasr_host_model
	import sasr_pkg::*;
(
	// clock
	input  wire logic        clk_sys,
	// register port
	output var sasr_req_t    req,
	output var logic [15:0]  wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        rvalid,
	input  wire logic        addr_hit
);
	initial begin
		req = '0;
		wdata = 16'h0000;
	end

	// w=1 writes d q and f hold the answer: f = {rvalid, addr_hit}
	task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic [15:0] f);
		@(posedge clk_sys);
		req <= '{rd: !w, wr: w, addr: a};
		wdata <= d;
		@(posedge clk_sys);
		// released address and data lines show the inverse, never the last value; rd and wr drop to 0
		req <= '{rd: 1'b0, wr: 1'b0, addr: ~a};
		wdata <= ~d;
		@(posedge clk_sys);
		q = rdata;
		f = {14'h0000, rvalid, addr_hit};
	endtask
endmodule
`default_nettype wire

/* File: verif/spectral_alarm_status_regs_bench.sv */
/*
 bench for sasr_regs: random alarm results, straps, writes and captures.
 assumes: the seconds tick is shortened to TICK cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module spectral_alarm_status_regs_bench;
	import sasr_pkg::*;
	localparam int unsigned TICK = 4;
	logic          clk_sys;
	logic          sys_rst;
	logic          capture_event;
	sasr_req_t     req;
	logic [15:0]   wdata;
	logic [15:0]   rdata;
	logic          rvalid;
	logic          addr_hit;
	sasr_result_t  result;
	sasr_day_rev_t day_rev_in;
	logic [2:0]    diag_alarm_lvl1;
	logic [2:0]    diag_alarm_lvl2;
	logic [31:0]   seed = 32'hf357;
	int            failures = 0;
	int            tests_run = 0;
	int            cyc = 0;
	logic [6:0]    adr [9] = '{7'h40, 7'h42, 7'h44, 7'h46, 7'h48, 7'h4a, 7'h4c, 7'h4e, 7'h52};
	logic [15:0]   expw [9];

	sasr_regs #(.SEC_TICK_CYCLES(TICK)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.req(req), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .addr_hit(addr_hit),
		.result(result), .capture_event(capture_event), .day_rev_in(day_rev_in),
		.diag_alarm_lvl1(diag_alarm_lvl1), .diag_alarm_lvl2(diag_alarm_lvl2));
	sasr_host_model u_host (.clk_sys(clk_sys), .req(req), .wdata(wdata), .rdata(rdata),
		.rvalid(rvalid), .addr_hit(addr_hit));

	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] exp_stat(input sasr_axis_t a);
		logic [15:0] w;
		w = 16'h0000;
		for (int n = 0; n < 6; n++) begin
			w[2*n+4] = a.lvl1[n];
			w[2*n+5] = a.lvl2[n];
		end
		if (a.band >= 3'h1 && a.band <= 3'h6) w[2:0] = a.band;
		return w;
	endfunction

	task automatic check(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic conclude();
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic read_all();
		logic [15:0] q;
		logic [15:0] f;
		for (int i = 0; i < 9; i++) begin
			u_host.access(1'b0, adr[i], 16'h0000, q, f);
			check(q, expw[i]);
			check(f, 16'h0003);
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) if (!sys_rst) cyc <= cyc + 1;

	initial begin
		#(40ns * 20000);
		failures++;
		conclude();
	end

	initial begin
		sasr_axis_t  ax [3];
		logic [15:0] pk [3];
		logic [15:0] q;
		logic [15:0] f;
		logic [15:0] e;
		int          c;
		sys_rst = 1'b1;
		capture_event = 1'b0;
		result = '0;
		for (int i = 0; i < 4; i++) day_rev_in[4*i+:4] = 4'(xs() % 10);
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		foreach (expw[i]) expw[i] = 16'h0000;
		expw[8] = {day_rev_in.day_tens, day_rev_in.day_units, day_rev_in.rev_msd,
			day_rev_in.rev_lsd};
		read_all();
		u_host.access(1'b0, 7'h50, 16'h0000, q, f);
		check(q, 16'h0000);
		check(f, 16'h0002);
		u_host.access(1'b0, 7'h53, 16'h0000, q, f);
		check(q, expw[8]);
		for (int k = 0; k < 9; k++) begin
			for (int i = 0; i < 3; i++) begin
				{pk[i], ax[i]} = 31'(xs());
				// corner bands outside the legal range come first
				if (k < 2) ax[i].band = k ? 3'h7 : 3'h0;
				expw[i] = exp_stat(ax[i]);
				expw[3+i] = pk[i];
			end
			@(posedge clk_sys);
			result <= {1'b1, ax[0], ax[1], ax[2], pk[0], pk[1], pk[2]};
			@(posedge clk_sys);
			result.valid <= 1'b0;
			@(posedge clk_sys);
			e = {10'h000, |ax[2].lvl2, |ax[1].lvl2, |ax[0].lvl2,
				|ax[2].lvl1, |ax[1].lvl1, |ax[0].lvl1};
			check({10'h000, diag_alarm_lvl2, diag_alarm_lvl1}, e);
			u_host.access(1'b1, adr[k], 16'(xs()), q, f);
			read_all();
		end
		repeat (100) @(posedge clk_sys);
		capture_event <= 1'b1;
		c = cyc;
		@(posedge clk_sys);
		capture_event <= 1'b0;
		repeat (20) @(posedge clk_sys);
		for (int r = 0; r < 2; r++) begin
			u_host.access(1'b0, OFS_SECONDS_LOW, 16'h0000, q, f);
			// c misses the capture edge itself, whose seconds the stamp takes
			e = 16'((c + 1) / TICK);
			check(q, e);
			u_host.access(1'b0, OFS_SECONDS_HIGH, 16'h0000, q, f);
			check(q, 16'(((c + 1) / TICK) >> 16));
		end
		// mid-run reset with fresh straps: words clear, day word retaken
		for (int i = 0; i < 4; i++) e[4*i+:4] = 4'(xs() % 10);
		sys_rst <= 1'b1;
		day_rev_in <= e;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		foreach (expw[i]) expw[i] = 16'h0000;
		expw[8] = day_rev_in;
		read_all();
		conclude();
	end
endmodule
`default_nettype wire
